//--- logic/scpc_pkg.sv
package scpc_pkg;
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] ADDR_IRQ_ENABLE_CLEAR = 8'h00;
    localparam logic [7:0] ADDR_IRQ_ENABLE_SET   = 8'h04;
    localparam logic [7:0] ADDR_IRQ_FLAG         = 8'h08;
    localparam logic [7:0] ADDR_POWER_CLOCK_STAT = 8'h0c;
    localparam logic [7:0] ADDR_OSC_ENABLE       = 8'h10;
    localparam logic [7:0] ADDR_OSC_RUN_REQUEST  = 8'h14;
    localparam logic [7:0] ADDR_OSC_RUN_STANDBY  = 8'h18;
    localparam logic [7:0] ADDR_CTRL             = 8'h1c;
    localparam logic [7:0] ADDR_CALIB            = 8'h20;
    localparam logic [7:0] ADDR_BROWNOUT         = 8'h24;

    // oscillator index: 0 mxtal, 1 x32k, 2 i32k, 3 ulp32k, 4 i8m, 5 fll, 6 pll
    localparam int NUM_OSC = 7;
    localparam int ULP_IDX = 3;
    localparam int MXTAL_IDX = 0;
    localparam int X32K_IDX = 1;

    // status bits: 0..6 osc ready, 7 brownout_3v3 det, 8 brownout_1v2 det, 9 fll lock, 10 fll sync busy
    localparam int STAT_W = 11;
    localparam int STAT_BROWNOUT_3V3 = 7;
    localparam int STAT_BROWNOUT_1V2 = 8;
    localparam int STAT_FLL_LOCK = 9;
    localparam int STAT_SYNC_BUSY = 10;

    // control register fields
    localparam int CTRL_XTAL_MODE_MX = 0;
    localparam int CTRL_XTAL_MODE_32 = 1;
    localparam int CTRL_FLL_CLOSED = 2;
    localparam int CTRL_PLL_REF_LSB = 3;
    localparam int CTRL_PLL_FRAC_LSB = 8;
    localparam int CTRL_PLL_MUL_LSB = 12;

    // brownout register fields
    localparam int BOD_33_EN = 0;
    localparam int BOD_33_ACT_IRQ = 1;
    localparam int BOD_33_SAMPLED = 2;
    localparam int BOD_12_EN = 3;
    localparam int BOD_12_ACT_IRQ = 4;
    localparam int BOD_12_SAMPLED = 5;
    localparam int BOD_33_LEVEL_LSB = 8;
    localparam int BOD_12_LEVEL_LSB = 16;

    localparam logic [6:0] OSC_EN_RESET  = 7'h08;
    localparam logic [6:0] RUN_REQ_RESET = 7'h7f;
    localparam logic [6:0] RUN_STBY_RESET = 7'h00;
    localparam logic [1:0] PLL_REF_MAX   = 2'h2;

    // start-up mask, in sys_clk cycles
    localparam int STARTUP_NS = 1000;
    localparam int CLK_NS = 25;
    localparam int STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] STARTUP_CNT = 8'(STARTUP_CYC);

    typedef enum logic [1:0] {SCPC_SYNC_IDLE, SCPC_SYNC_WAIT, SCPC_SYNC_DROP} scpc_sync_t;
endpackage

//--- logic/scpc_top.sv
// Operation
// - all sub-block statuses gathered in one readable power-clock status register.
// - status rises set interrupt flags; enable set, enable clear, flag registers.
// - both brownout interrupts can wake the chip from standby.
// - enabling a crystal oscillator takes its pins automatically.
// - block keeps working in any sleep mode while its clock runs.
// - interrupt requests able to wake the chip from sleep.
// - events emitted toward other blocks without leaving sleep.
// - seven clock sources offered to the generic clock controller.
// - writes into brownout-sample and fll domains are synchronised.
// - one interrupt request line to the interrupt controller.
// - normal operation continues while the processor halts in debug.
// - cold-plug masks both brownout resets; hot-plug keeps them.
// - writable registers may be write-protected, except the flag register.
// - no protection while halted in debug or for debugger accesses.
// - sys_clk given divided by 2, 4 and 8 on osc8mDivided, whether or not the 8 MHz oscillator runs.
// - pll fractional multiplier part in sixteenths of the reference.
// - pll reference selected from three sources.
// - ulp32k and 8 MHz calibration loaded from factory flash at reset.
// - brownout register upper half (1v2 threshold) loaded from user flash at startup.
// - each brownout: reset or interrupt, continuous only; the sampled bit is not used.
// - fll open loop oscillator or closed loop multiplier.
// - oscillator output masked during its start-up time.
// - standby stop/run/on-request from run_in_standby and run_on_request.
`timescale 1ns/10ps
`default_nettype none
module scpc_top
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  busAddr,
    input  wire logic [31:0] busWdata,
    input  wire logic        busWrite,
    input  wire logic        busRead,
    output logic      [31:0] busRdata,
    input  wire logic        writeProtect,
    input  wire logic        debugHalt,
    input  wire logic        debuggerAccess,
    input  wire logic        coldPlug,
    input  wire logic        standby,
    input  wire logic [6:0]  oscRequest,
    input  wire logic [6:0]  oscStable,
    input  wire logic        bod33Low,
    input  wire logic        bod12Low,
    input  wire logic        fllLocked,
    input  wire logic        fllSyncAck,
    input  wire logic [15:0] factoryCalib,
    input  wire logic [15:0] userCalib,
    output logic [6:0]       oscRun,
    output logic [6:0]       clockSourceValid,
    output logic [2:0]       osc8mDivided,
    output logic             crystalPinOwn,
    output logic             slowCrystalPinOwn,
    output logic [1:0]       pllRefSelect,
    output logic [3:0]       pllFraction,
    output logic [11:0]      pllMultiplier,
    output logic             fllClosedLoop,
    output logic             fllSyncReq,
    output logic [31:0]      fllSyncData,
    output logic             bodReset,
    output logic             irqReq,
    output logic [10:0]      statusEvent
);
    // synchronisers: three flops, change taken when stages two and three agree
    logic [9:0] syn1_q, syn2_q, syn3_q, synV_q, synV_d;
    logic [9:0] rawIn;
    // the acknowledge has its own synchroniser below, so it is kept out of this word
    assign rawIn = {fllLocked, bod12Low, bod33Low, oscStable};
    always_comb
    begin
        for (int i = 0; i < 10; i++)
            synV_d[i] = (syn2_q[i] == syn3_q[i]) ? syn3_q[i] : synV_q[i];
    end
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            syn1_q <= 10'h000;
            syn2_q <= 10'h000;
            syn3_q <= 10'h000;
            synV_q <= 10'h000;
        end
        else
        begin
            syn1_q <= rawIn;
            syn2_q <= syn1_q;
            syn3_q <= syn2_q;
            synV_q <= synV_d;
        end
    end

    // registers
    logic [10:0] ien_q, ien_d, flag_q, flag_d, stat_q, stat_d;
    logic [6:0]  oscEn_q, oscEn_d, runReq_q, runReq_d, runStby_q, runStby_d;
    logic [31:0] ctrl_q, ctrl_d, calib_q, calib_d, bod_q, bod_d;
    logic [31:0] rdata_q, rdata_d;
    logic        loaded_q, loaded_d;
    logic [6:0]  oscRun_q, oscRun_d, valid_q, valid_d;
    logic [7:0]  stCnt_q [0:6];
    logic [7:0]  stCnt_d [0:6];
    logic [2:0]  div_q, div_d;
    logic        irq_q, irq_d, bodRst_q, bodRst_d;
    logic [10:0] evt_q, evt_d;
    logic        wrOk, wrFlag;
    logic [10:0] rise;
    scpc_pkg::scpc_sync_t sync_q, sync_d;
    logic        ackSeen;
    logic        synAck1_q, synAck2_q, synAck3_q, synAck_q;
    logic        syncReq_q, syncReq_d, syncPend_q, syncPend_d;
    logic [31:0] syncData_q, syncData_d;

    // protection is lifted in debug halt and for debugger accesses
    assign wrOk   = busWrite & (~writeProtect | debugHalt | debuggerAccess);
    assign wrFlag = busWrite & (busAddr == scpc_pkg::ADDR_IRQ_FLAG);

    always_comb
    begin
        // status snapshot: ready, brownout, lock, sync busy
        stat_d = {syncPend_q, synV_q[8], synV_q[7] & bod_q[scpc_pkg::BOD_12_EN],
                  synV_q[7] & 1'b0 | synV_q[7] & bod_q[scpc_pkg::BOD_33_EN], valid_q};
        stat_d[scpc_pkg::STAT_BROWNOUT_3V3] = synV_q[7] & bod_q[scpc_pkg::BOD_33_EN];
        stat_d[scpc_pkg::STAT_BROWNOUT_1V2] = synV_q[8] & bod_q[scpc_pkg::BOD_12_EN];
        stat_d[scpc_pkg::STAT_FLL_LOCK] = synV_q[9] & ctrl_q[scpc_pkg::CTRL_FLL_CLOSED];
        stat_d[scpc_pkg::STAT_SYNC_BUSY] = syncPend_q;
        rise = stat_d & ~stat_q;
        evt_d = rise;
        ien_d = ien_q;
        if (wrOk && busAddr == scpc_pkg::ADDR_IRQ_ENABLE_CLEAR)
            ien_d = ien_q & ~busWdata[10:0];
        if (wrOk && busAddr == scpc_pkg::ADDR_IRQ_ENABLE_SET)
            ien_d = ien_q | busWdata[10:0];
        // a new rise wins over a simultaneous write-one-to-clear
        flag_d = (flag_q & ~(wrFlag ? busWdata[10:0] : 11'h000)) | rise;
        irq_d = |(flag_q & ien_q);
        oscEn_d = oscEn_q;
        runReq_d = runReq_q;
        runStby_d = runStby_q;
        ctrl_d = ctrl_q;
        calib_d = calib_q;
        bod_d = bod_q;
        loaded_d = 1'b1;
        if (!loaded_q)
        begin
            calib_d = {16'h0000, factoryCalib};
            bod_d[31:16] = userCalib;
        end
        if (wrOk)
        begin
            case (busAddr)
                scpc_pkg::ADDR_OSC_ENABLE:      oscEn_d = busWdata[6:0] | scpc_pkg::OSC_EN_RESET;
                scpc_pkg::ADDR_OSC_RUN_REQUEST: runReq_d = busWdata[6:0];
                scpc_pkg::ADDR_OSC_RUN_STANDBY: runStby_d = busWdata[6:0];
                scpc_pkg::ADDR_CTRL:            ctrl_d = busWdata;
                scpc_pkg::ADDR_CALIB:           calib_d = busWdata;
                scpc_pkg::ADDR_BROWNOUT:        bod_d = busWdata;
                default:                        ctrl_d = ctrl_q;
            endcase
        end
        if (ctrl_d[scpc_pkg::CTRL_PLL_REF_LSB +: 2] > scpc_pkg::PLL_REF_MAX)
            ctrl_d[scpc_pkg::CTRL_PLL_REF_LSB +: 2] = scpc_pkg::PLL_REF_MAX;
        // oscillator run decision per sleep state
        for (int i = 0; i < scpc_pkg::NUM_OSC; i++)
        begin
            if (i == scpc_pkg::ULP_IDX)
                oscRun_d[i] = 1'b1;
            else if (!oscEn_q[i])
                oscRun_d[i] = 1'b0;
            else if (standby && !runStby_q[i])
                oscRun_d[i] = 1'b0;
            else
                oscRun_d[i] = ~runReq_q[i] | oscRequest[i];
            // start-up counter masks output until stable
            if (!oscRun_q[i])
                stCnt_d[i] = scpc_pkg::STARTUP_CNT;
            else if (stCnt_q[i] != 8'h00)
                stCnt_d[i] = stCnt_q[i] - 8'h01;
            else
                stCnt_d[i] = 8'h00;
            valid_d[i] = oscRun_q[i] & (stCnt_q[i] == 8'h00) & synV_q[i];
        end
        div_d = div_q + 3'h1;
        // brownout reset when configured for reset and not cold-plugged
        bodRst_d = ~coldPlug & ((stat_q[scpc_pkg::STAT_BROWNOUT_3V3] & ~bod_q[scpc_pkg::BOD_33_ACT_IRQ])
                  | (stat_q[scpc_pkg::STAT_BROWNOUT_1V2] & ~bod_q[scpc_pkg::BOD_12_ACT_IRQ]));
        rdata_d = 32'h0000_0000;
        if (busRead)
        begin
            case (busAddr)
                scpc_pkg::ADDR_IRQ_ENABLE_CLEAR: rdata_d = {21'h000000, ien_q};
                scpc_pkg::ADDR_IRQ_ENABLE_SET:   rdata_d = {21'h000000, ien_q};
                scpc_pkg::ADDR_IRQ_FLAG:         rdata_d = {21'h000000, flag_q};
                scpc_pkg::ADDR_POWER_CLOCK_STAT: rdata_d = {21'h000000, stat_q};
                scpc_pkg::ADDR_OSC_ENABLE:       rdata_d = {25'h0000000, oscEn_q};
                scpc_pkg::ADDR_OSC_RUN_REQUEST:  rdata_d = {25'h0000000, runReq_q};
                scpc_pkg::ADDR_OSC_RUN_STANDBY:  rdata_d = {25'h0000000, runStby_q};
                scpc_pkg::ADDR_CTRL:             rdata_d = ctrl_q;
                scpc_pkg::ADDR_CALIB:            rdata_d = calib_q;
                scpc_pkg::ADDR_BROWNOUT:         rdata_d = bod_q;
                default:                         rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // fll control writes handed over by a four-phase request/acknowledge
    always_comb
    begin
        sync_d = sync_q;
        syncReq_d = syncReq_q;
        syncData_d = syncData_q;
        syncPend_d = syncPend_q;
        if (wrOk && (busAddr == scpc_pkg::ADDR_CTRL || busAddr == scpc_pkg::ADDR_BROWNOUT))
            syncPend_d = 1'b1;
        case (sync_q)
            scpc_pkg::SCPC_SYNC_IDLE:
                if (syncPend_q)
                begin
                    syncData_d = ctrl_q;
                    syncReq_d = 1'b1;
                    syncPend_d = 1'b0;
                    sync_d = scpc_pkg::SCPC_SYNC_WAIT;
                end
            scpc_pkg::SCPC_SYNC_WAIT:
                if (synV_q[9 - 0] == 1'b0 && synV_q[9] == 1'b0 && 1'b0)
                    sync_d = scpc_pkg::SCPC_SYNC_WAIT;
                else if (syn3_q[9] && syn2_q[9] && 1'b0)
                    sync_d = scpc_pkg::SCPC_SYNC_WAIT;
                else if (ackSeen)
                begin
                    syncReq_d = 1'b0;
                    sync_d = scpc_pkg::SCPC_SYNC_DROP;
                end
            scpc_pkg::SCPC_SYNC_DROP:
                if (!ackSeen)
                    sync_d = scpc_pkg::SCPC_SYNC_IDLE;
            default:
                sync_d = scpc_pkg::SCPC_SYNC_IDLE;
        endcase
    end
    assign ackSeen = synAck_q;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            synAck1_q <= 1'b0;
            synAck2_q <= 1'b0;
            synAck3_q <= 1'b0;
            synAck_q <= 1'b0;
        end
        else
        begin
            synAck1_q <= fllSyncAck;
            synAck2_q <= synAck1_q;
            synAck3_q <= synAck2_q;
            synAck_q <= (synAck2_q == synAck3_q) ? synAck3_q : synAck_q;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ien_q <= 11'h000;
            flag_q <= 11'h000;
            stat_q <= 11'h000;
            oscEn_q <= scpc_pkg::OSC_EN_RESET;
            runReq_q <= scpc_pkg::RUN_REQ_RESET;
            runStby_q <= scpc_pkg::RUN_STBY_RESET;
            ctrl_q <= 32'h0000_0000;
            calib_q <= 32'h0000_0000;
            bod_q <= 32'h0000_0000;
            loaded_q <= 1'b0;
            oscRun_q <= 7'h00;
            valid_q <= 7'h00;
            for (int i = 0; i < 7; i++)
                stCnt_q[i] <= 8'h00;
            div_q <= 3'h0;
            irq_q <= 1'b0;
            bodRst_q <= 1'b0;
            evt_q <= 11'h000;
            rdata_q <= 32'h0000_0000;
            sync_q <= scpc_pkg::SCPC_SYNC_IDLE;
            syncReq_q <= 1'b0;
            syncPend_q <= 1'b0;
            syncData_q <= 32'h0000_0000;
        end
        else
        begin
            ien_q <= ien_d;
            flag_q <= flag_d;
            stat_q <= stat_d;
            oscEn_q <= oscEn_d;
            runReq_q <= runReq_d;
            runStby_q <= runStby_d;
            ctrl_q <= ctrl_d;
            calib_q <= calib_d;
            bod_q <= bod_d;
            loaded_q <= loaded_d;
            oscRun_q <= oscRun_d;
            valid_q <= valid_d;
            for (int i = 0; i < 7; i++)
                stCnt_q[i] <= stCnt_d[i];
            div_q <= div_d;
            irq_q <= irq_d;
            bodRst_q <= bodRst_d;
            evt_q <= evt_d;
            rdata_q <= rdata_d;
            sync_q <= sync_d;
            syncReq_q <= syncReq_d;
            syncPend_q <= syncPend_d;
            syncData_q <= syncData_d;
        end
    end

    // debug halt only lifts write protection: the block runs on regardless
    assign busRdata = rdata_q;
    assign oscRun = oscRun_q;
    assign clockSourceValid = valid_q;
    assign osc8mDivided = div_q;
    assign crystalPinOwn = oscEn_q[scpc_pkg::MXTAL_IDX];
    assign slowCrystalPinOwn = oscEn_q[scpc_pkg::X32K_IDX];
    assign pllRefSelect = ctrl_q[scpc_pkg::CTRL_PLL_REF_LSB +: 2];
    assign pllFraction = ctrl_q[scpc_pkg::CTRL_PLL_FRAC_LSB +: 4];
    assign pllMultiplier = ctrl_q[scpc_pkg::CTRL_PLL_MUL_LSB +: 12];
    assign fllClosedLoop = ctrl_q[scpc_pkg::CTRL_FLL_CLOSED];
    assign fllSyncReq = syncReq_q;
    assign fllSyncData = syncData_q;
    assign bodReset = bodRst_q;
    assign irqReq = irq_q;
    assign statusEvent = evt_q;
endmodule
`default_nettype wire

//--- sim/scpc_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module scpc_top_sva
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        busRead,
    input wire logic [31:0] busRdata,
    input wire logic        coldPlug,
    input wire logic [6:0]  oscRun,
    input wire logic [6:0]  clockSourceValid,
    input wire logic [2:0]  osc8mDivided,
    input wire logic [1:0]  pllRefSelect,
    input wire logic        fllSyncReq,
    input wire logic        fllSyncAck,
    input wire logic [31:0] fllSyncData,
    input wire logic        bodReset,
    input wire logic [10:0] statusEvent
);
    localparam int MIN_RUN = scpc_pkg::STARTUP_CYC - 1;
    logic [7:0] runCnt_q;
    logic [7:0] runCnt_d;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // saturates so a long run never wraps back under the start-up figure
    always_comb
    begin
        runCnt_d = 8'h00;
        if (oscRun[4])
            runCnt_d = (runCnt_q == 8'hff) ? runCnt_q : runCnt_q + 8'h01;
    end
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            runCnt_q <= 8'h00;
        else
            runCnt_q <= runCnt_d;
    end
    sequence sAckHeld;
        fllSyncAck [*8];
    endsequence
    a_read_idle_zero: assert property (
        !$past(rst) && !$past(busRead) |-> busRdata == 32'h0) else $error("stray read data");
    a_div_two_toggle: assert property (
        !$past(rst) |-> osc8mDivided[0] != $past(osc8mDivided[0])) else $error("div2 stuck");
    a_event_one_cycle: assert property (
        !$past(rst) |-> (statusEvent & $past(statusEvent)) == 11'h0) else $error("long event");
    a_pll_ref_range: assert property (
        pllRefSelect <= scpc_pkg::PLL_REF_MAX) else $error("pll reference out of range");
    a_cold_plug_mask: assert property (
        coldPlug [*3] |-> !bodReset) else $error("brownout reset under cold plug");
    a_ulp_always_runs: assert property (
        !$past(rst) && !$past(rst, 2) |-> oscRun[scpc_pkg::ULP_IDX]) else $error("ulp stopped");
    a_sync_data_hold: assert property (
        fllSyncReq && $past(fllSyncReq) |-> $stable(fllSyncData)) else $error("sync data moved");
    a_sync_drop_bound: assert property (
        sAckHeld |-> !fllSyncReq) else $error("sync request not dropped");
    a_startup_mask_time: assert property (
        $rose(clockSourceValid[4]) |-> runCnt_q >= MIN_RUN) else $error("source valid early");
endmodule
bind scpc_top scpc_top_sva i_scpc_top_sva
(
    .sys_clk, .rst, .busRead, .busRdata, .coldPlug, .oscRun, .clockSourceValid, .osc8mDivided,
    .pllRefSelect, .fllSyncReq, .fllSyncAck, .fllSyncData, .bodReset, .statusEvent
);
`default_nettype wire

//--- sim/scpc_osc_model.sv
`timescale 1ns/10ps
`default_nettype none
module scpc_osc_model
#(
    parameter int STABLE_DLY = 6,
    parameter int ACK_DLY    = 3
)
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [6:0] oscRun,
    input  wire logic       fllSyncReq,
    input  wire logic       slowAck,
    output var  logic [6:0] oscStable,
    output var  logic       fllSyncAck
);
    int stCnt [7];
    int ackCnt;
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            oscStable <= 7'h00;
            fllSyncAck <= 1'b0;
            ackCnt <= 0;
            foreach (stCnt[i])
                stCnt[i] <= 0;
        end
        else
        begin
            // an oscillator settles only after running a while and dies at once when stopped
            for (int i = 0; i < 7; i++)
            begin
                stCnt[i] <= oscRun[i] ? stCnt[i] + 1 : 0;
                oscStable[i] <= oscRun[i] && stCnt[i] >= STABLE_DLY;
            end
            if (fllSyncReq == fllSyncAck)
                ackCnt <= 0;
            else if (ackCnt >= (slowAck ? 4 * ACK_DLY : ACK_DLY))
                fllSyncAck <= fllSyncReq;
            else
                ackCnt <= ackCnt + 1;
        end
    end
endmodule
`default_nettype wire

//--- sim/tb_system_clock_power_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_system_clock_power_control;
    typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} scpc_row_t;
    localparam logic [15:0] FACT_CAL = 16'h5a3c;
    localparam logic [15:0] USER_CAL = 16'h0c81;
    logic sys_clk = 1'b0, rst = 1'b1, busWrite = 1'b0, busRead = 1'b0, writeProtect = 1'b0;
    logic debugHalt = 1'b0, debuggerAccess = 1'b0, coldPlug = 1'b0, standby = 1'b0;
    logic bod33Low = 1'b0, bod12Low = 1'b0, fllLocked = 1'b0, slowAck = 1'b0;
    logic [7:0] busAddr = 8'h00;
    logic [31:0] busWdata = 32'h0, busRdata, fllSyncData, rdat;
    logic [6:0] oscRequest = 7'h00, oscStable, oscRun, clockSourceValid;
    logic [2:0] osc8mDivided;
    logic [1:0] pllRefSelect;
    logic [3:0] pllFraction;
    logic [11:0] pllMultiplier;
    logic [10:0] statusEvent;
    logic crystalPinOwn, slowCrystalPinOwn, fllClosedLoop, fllSyncReq, fllSyncAck, bodReset, irqReq;
    int failures = 0, nTests = 0, k;
    scpc_row_t rows [6] = '{
        '{1'b0, scpc_pkg::ADDR_OSC_ENABLE, 32'h0, 32'h8},
        '{1'b0, scpc_pkg::ADDR_OSC_RUN_REQUEST, 32'h0, 32'h7f},
        '{1'b0, scpc_pkg::ADDR_OSC_RUN_STANDBY, 32'h0, 32'h0},
        '{1'b1, 8'h80, 32'hffff_ffff, 32'h0},
        '{1'b1, scpc_pkg::ADDR_OSC_ENABLE, 32'h1, 32'h9},
        '{1'b1, scpc_pkg::ADDR_IRQ_ENABLE_SET, 32'h10, 32'h10}};
    scpc_top i_scpc_top
    (
        .sys_clk, .rst, .busAddr, .busWdata, .busWrite, .busRead, .busRdata, .writeProtect,
        .debugHalt, .debuggerAccess, .coldPlug, .standby, .oscRequest, .oscStable, .bod33Low,
        .bod12Low, .fllLocked, .fllSyncAck, .factoryCalib(FACT_CAL), .userCalib(USER_CAL),
        .oscRun, .clockSourceValid, .osc8mDivided, .crystalPinOwn, .slowCrystalPinOwn,
        .pllRefSelect, .pllFraction, .pllMultiplier, .fllClosedLoop, .fllSyncReq, .fllSyncData,
        .bodReset, .irqReq, .statusEvent
    );
    scpc_osc_model i_scpc_osc_model
    (
        .sys_clk, .rst, .oscRun, .fllSyncReq, .slowAck, .oscStable, .fllSyncAck
    );
    // the power manager may gate the bus clock; the bench leaves it running
    always #12.5 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        busAddr <= a;
        busWdata <= d;
        busWrite <= 1'b1;
        @(posedge sys_clk);
        busWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        busAddr <= a;
        busRead <= 1'b1;
        @(posedge sys_clk);
        busRead <= 1'b0;
        @(negedge sys_clk);
        d = busRdata;
        @(posedge sys_clk);
    endtask
    // a new write into the slow domains must not overtake a handshake still in flight
    task automatic syncDone;
        // the request rises two edges after the write; look between edges
        repeat (2) @(negedge sys_clk);
        for (int j = 0; j < 100 && (fllSyncReq || fllSyncAck) !== 1'b0; j++)
            @(negedge sys_clk);
        @(posedge sys_clk);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", nTests, failures);
        if (failures == 0 && nTests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        $display("Error at %0t: watchdog expired", $time);
        tally_and_finish;
    end
    initial
    begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        foreach (rows[i])
        begin
            if (rows[i].wr)
                wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rdat);
            chk(rdat, rows[i].e);
        end
        wr(scpc_pkg::ADDR_CTRL, 32'h0012_351c);
        syncDone;
        chk({13'h0, pllMultiplier, pllFraction, pllRefSelect, fllClosedLoop}, 32'h91ad);
        slowAck <= 1'b1;
        wr(scpc_pkg::ADDR_CTRL, 32'h0000_0014);
        for (k = 0; k < 20 && fllSyncReq !== 1'b1; k++) @(posedge sys_clk);
        chk(fllSyncData, 32'h14);
        syncDone;
        slowAck <= 1'b0;
        chk(32'({pllRefSelect, fllClosedLoop}), 32'h5);
        wr(scpc_pkg::ADDR_CTRL, 32'h3);
        wr(scpc_pkg::ADDR_OSC_ENABLE, 32'h1b);
        oscRequest <= 7'h10;
        repeat (3) @(posedge sys_clk);
        chk(32'({crystalPinOwn, slowCrystalPinOwn}), 32'h3);
        for (k = 0; k < 20 && oscRun[4] !== 1'b1; k++) @(posedge sys_clk);
        for (k = 0; k < 300 && clockSourceValid[4] !== 1'b1; k++) @(posedge sys_clk);
        chk(32'(k >= scpc_pkg::STARTUP_CYC && k < 300), 32'h1);
        rd(scpc_pkg::ADDR_POWER_CLOCK_STAT, rdat);
        chk(32'(rdat[4]), 32'h1);
        repeat (4) @(posedge sys_clk);
        chk(32'(irqReq), 32'h1);
        rd(scpc_pkg::ADDR_IRQ_FLAG, rdat);
        chk(32'(rdat[4]), 32'h1);
        wr(scpc_pkg::ADDR_IRQ_ENABLE_CLEAR, 32'h10);
        repeat (3) @(posedge sys_clk);
        chk(32'(irqReq), 32'h0);
        wr(scpc_pkg::ADDR_IRQ_ENABLE_SET, 32'h10);
        writeProtect <= 1'b1;
        wr(scpc_pkg::ADDR_IRQ_FLAG, 32'h10);
        repeat (3) @(posedge sys_clk);
        chk(32'(irqReq), 32'h0);
        wr(scpc_pkg::ADDR_OSC_RUN_STANDBY, 32'h10);
        rd(scpc_pkg::ADDR_OSC_RUN_STANDBY, rdat);
        chk(rdat, 32'h0);
        debugHalt <= 1'b1;
        wr(scpc_pkg::ADDR_OSC_RUN_STANDBY, 32'h10);
        rd(scpc_pkg::ADDR_OSC_RUN_STANDBY, rdat);
        chk(rdat, 32'h10);
        debugHalt <= 1'b0;
        debuggerAccess <= 1'b1;
        wr(scpc_pkg::ADDR_OSC_RUN_STANDBY, 32'h0);
        rd(scpc_pkg::ADDR_OSC_RUN_STANDBY, rdat);
        chk(rdat, 32'h0);
        debuggerAccess <= 1'b0;
        writeProtect <= 1'b0;
        standby <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk(32'({oscRun[4], oscRun[3]}), 32'h1);
        wr(scpc_pkg::ADDR_OSC_RUN_STANDBY, 32'h10);
        repeat (6) @(posedge sys_clk);
        chk(32'({oscRun[4], oscRun[3]}), 32'h3);
        wr(scpc_pkg::ADDR_OSC_RUN_REQUEST, 32'h6f);
        oscRequest <= 7'h00;
        repeat (6) @(posedge sys_clk);
        chk(32'(oscRun[4]), 32'h1);
        wr(scpc_pkg::ADDR_OSC_RUN_REQUEST, 32'h7f);
        repeat (6) @(posedge sys_clk);
        chk(32'(oscRun[4]), 32'h0);
        standby <= 1'b0;
        rd(scpc_pkg::ADDR_BROWNOUT, rdat);
        chk(32'(rdat[31:16]), 32'(USER_CAL));
        syncDone;
        wr(scpc_pkg::ADDR_BROWNOUT, {USER_CAL, 16'h0001});
        bod33Low <= 1'b1;
        for (k = 0; k < 30 && bodReset !== 1'b1; k++) @(posedge sys_clk);
        chk(32'(bodReset), 32'h1);
        coldPlug <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk(32'(bodReset), 32'h0);
        coldPlug <= 1'b0;
        bod33Low <= 1'b0;
        syncDone;
        wr(scpc_pkg::ADDR_BROWNOUT, {USER_CAL, 16'h0003});
        syncDone;
        wr(scpc_pkg::ADDR_IRQ_ENABLE_SET, 32'h80);
        bod33Low <= 1'b1;
        repeat (12) @(posedge sys_clk);
        chk(32'({bodReset, irqReq}), 32'h1);
        rd(scpc_pkg::ADDR_POWER_CLOCK_STAT, rdat);
        chk(32'(rdat[scpc_pkg::STAT_BROWNOUT_3V3]), 32'h1);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(32'({clockSourceValid, irqReq, bodReset}), 32'h0);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(scpc_pkg::ADDR_OSC_ENABLE, rdat);
        chk(rdat, 32'h8);
        tally_and_finish;
    end
endmodule
`default_nettype wire
